// file: lpt_pkg.sv
// package: register map, fields, timing and carrier types
package lpt_pkg;
    // ------------------------------------------------------------
    // bus address and command codes
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR      = 7'h60;
    localparam logic [7:0] CMD_ALS_CONF  = 8'h00;
    localparam logic [7:0] CMD_ALS_THH   = 8'h01;
    localparam logic [7:0] CMD_ALS_THL   = 8'h02;
    localparam logic [7:0] CMD_PRX_CONF  = 8'h03;
    localparam logic [7:0] CMD_PRX_CONF3 = 8'h04;
    localparam logic [7:0] CMD_CANCEL    = 8'h05;
    localparam logic [7:0] CMD_PRX_THL   = 8'h06;
    localparam logic [7:0] CMD_PRX_THH   = 8'h07;
    localparam logic [7:0] CMD_PRX_DATA  = 8'h08;
    localparam logic [7:0] CMD_ALS_DATA  = 8'h0b;
    localparam logic [7:0] CMD_FLAGS     = 8'h0d;
    localparam logic [7:0] CMD_IDENT     = 8'h0e;
    localparam int         NUM_WR        = 8;
    // ------------------------------------------------------------
    // field positions inside the 16-bit words and the flag byte
    // ------------------------------------------------------------
    localparam int IT_LSB      = 5;
    localparam int APERS_LSB   = 2;
    localparam int AIEN_BIT    = 1;
    localparam int PPERS_LSB   = 4;
    localparam int PIMODE_LSB  = 8;
    localparam int SCHEME_BIT  = 11;
    localparam int ONESHOT_BIT = 3;
    localparam int TRIG_BIT    = 2;
    localparam int LOGSEL_BIT  = 14;
    localparam int FLG_GEST    = 7;
    localparam int FLG_PROT    = 6;
    localparam int FLG_ALO     = 5;
    localparam int FLG_AHI     = 4;
    localparam int FLG_NEAR    = 1;
    localparam int FLG_FAR     = 0;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] REG_RST     = 16'h0000;
    localparam logic [15:0] IDENT_VAL   = 16'h0a51; // arbitrary value
    localparam int unsigned CLK_KHZ     = 250000;
    localparam int unsigned IT_BASE_MS  = 50;
    localparam int unsigned IT_BASE_CYC = IT_BASE_MS * CLK_KHZ;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] als;
        logic [15:0] prox;
    } lpt_meas_t;
    typedef enum logic [2:0] {
        I_IDLE = 3'b000, I_ADDR = 3'b001, I_CMD = 3'b010, I_WDAT = 3'b011,
        I_SACK = 3'b100, I_RDAT = 3'b101, I_MACK = 3'b110
    } lpt_i2c_t;
endpackage : lpt_pkg

// file: lpt_top.sv
// light and proximity threshold, persistence and interrupt logic
// Behaviour
// - ambient high and low thresholds are 16 bits, written low then high byte
// - ambient interrupt when result above high or below low, if enabled
// - integration code 000,001,010/011,100,101..111 gives 50,100,200,400,800 ms periods
// - ambient flag only after 1,2,4 or 8 consecutive periods outside window
// - proximity flag only after 1..4 consecutive periods beyond threshold
// - one-shot mode stays idle; each trigger write makes one measurement
// - every command register reads back its contents
// - ambient result read as low byte then high byte, one word read
// - cancel value is subtracted from each raw proximity value
// - both sources share one pin, pulled low while an interrupt stands
// - registers stay accessible while the interrupt is asserted
// - flag register records events; any new flag pulls the pin low
// - reading the flag byte clears shown flags; pin returns high
// - logic-output mode: pin low on approach, high when object leaves
// - logic-output mode pin shows only proximity state
// - proximity hysteresis: between thresholds, state and flags hold
// - proximity irq mode picks close, away or both events
// - all registers have reset defaults; bus works with no setup
// - flag byte: 7 gesture, 6 protect, 5 low, 4 high, 1 near, 0 far
// - device answers at seven-bit bus address 60 hex
`timescale 1ns/1ps

// ------------------------------------------------------------
// link side: front end runs on its own clock
// ------------------------------------------------------------
module lpt_link (
    input  wire logic              fe_clk,
    input  wire logic              rst,
    input  wire logic              req_tgl,
    input  wire logic              fe_done,
    input  wire lpt_pkg::lpt_meas_t fe_meas,
    output logic                   fe_start,
    output logic                   done_tgl,
    output lpt_pkg::lpt_meas_t     hold
);
    typedef struct packed {
        logic [1:0]         rs;
        logic [2:0]         rq;
        logic               start;
        logic               tgl;
        lpt_pkg::lpt_meas_t hold;
    } lpt_lk_t;
    lpt_lk_t s, next_s;

    // reset is resynchronised; request toggle turned into a start pulse
    always_comb begin
        next_s       = s;
        next_s.rs    = {s.rs[0], rst};
        next_s.rq    = {s.rq[1:0], req_tgl};
        next_s.start = s.rq[1] ^ s.rq[2];
        if (fe_done) begin
            next_s.hold = fe_meas; // stable until next done toggle
            next_s.tgl  = ~s.tgl;
        end
        if (s.rs[1]) begin
            next_s.rq    = '0;
            next_s.start = 1'b0;
            next_s.tgl   = 1'b0;
            next_s.hold  = '0;
        end
    end

    always_ff @(posedge fe_clk) begin
        s <= next_s;
    end

    assign fe_start = s.start;
    assign done_tgl = s.tgl;
    assign hold     = s.hold;
endmodule : lpt_link

// ------------------------------------------------------------
// core: bus target, registers, thresholds and pin
// ------------------------------------------------------------
module lpt_top #(
    parameter int unsigned BASE_CYC = lpt_pkg::IT_BASE_CYC
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    output logic                    int_out,
    output logic                    int_oe,
    input  wire logic               fe_clk,
    output logic                    fe_start,
    input  wire logic               fe_done,
    input  wire lpt_pkg::lpt_meas_t fe_meas
);
    typedef struct packed {
        logic [2:0]                        scl;
        logic [2:0]                        sda;
        logic [2:0]                        dq;
        lpt_pkg::lpt_i2c_t                 ist;
        lpt_pkg::lpt_i2c_t                 nxt;
        logic [3:0]                        bitc;
        logic [7:0]                        sh;
        logic [7:0]                        cmd;
        logic                              hi;
        logic                              oe;
        logic [7:0]                        shown;
        logic [lpt_pkg::NUM_WR-1:0][15:0]  regs;
        logic [15:0]                       als;
        logic [15:0]                       prox;
        logic [7:0]                        flags;
        logic                              near;
        logic [3:0]                        acnt;
        logic [2:0]                        ccnt;
        logic [2:0]                        fcnt;
        logic [31:0]                       tmr;
        logic                              req;
        logic                              pin;
    } lpt_st_t;
    lpt_st_t s, next_s;
    lpt_pkg::lpt_meas_t meas;
    logic done_tgl, done_ev, wr_ev, rd_clr, sr, sf;
    logic [15:0] p_new;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] it_shift(input logic [2:0] c);
        unique case (c)
            3'h0:    it_shift = 3'h0;
            3'h1:    it_shift = 3'h1;
            3'h2:    it_shift = 3'h2;
            3'h3:    it_shift = 3'h2;
            3'h4:    it_shift = 3'h3;
            default: it_shift = 3'h4;
        endcase
    endfunction : it_shift

    function automatic logic [7:0] rd_byte(input lpt_st_t t);
        logic [15:0] w;
        w = 16'h0000;
        if (t.cmd < 8'(lpt_pkg::NUM_WR)) w = t.regs[t.cmd[2:0]];
        else if (t.cmd == lpt_pkg::CMD_PRX_DATA) w = t.prox;
        else if (t.cmd == lpt_pkg::CMD_ALS_DATA) w = t.als;
        else if (t.cmd == lpt_pkg::CMD_FLAGS) w = {t.flags, 8'h00};
        else if (t.cmd == lpt_pkg::CMD_IDENT) w = lpt_pkg::IDENT_VAL;
        rd_byte = t.hi ? w[15:8] : w[7:0];
    endfunction : rd_byte

    lpt_link u_link (
        .fe_clk   (fe_clk),
        .rst      (rst),
        .req_tgl  (s.req),
        .fe_done  (fe_done),
        .fe_meas  (fe_meas),
        .fe_start (fe_start),
        .done_tgl (done_tgl),
        .hold     (meas)
    );

    wire [15:0] canc  = s.regs[lpt_pkg::CMD_CANCEL[2:0]];
    wire [15:0] c_a   = s.regs[lpt_pkg::CMD_ALS_CONF[2:0]];
    wire [15:0] c_p   = s.regs[lpt_pkg::CMD_PRX_CONF[2:0]];
    wire [15:0] c_p3  = s.regs[lpt_pkg::CMD_PRX_CONF3[2:0]];
    wire [3:0]  apers = 4'h1 << c_a[lpt_pkg::APERS_LSB +: 2];
    wire [2:0]  ppers = {1'b0, c_p[lpt_pkg::PPERS_LSB +: 2]} + 3'h1;
    wire        osm   = c_p3[lpt_pkg::ONESHOT_BIT];
    wire        lsel  = c_p3[lpt_pkg::LOGSEL_BIT];

    // synchronised edges; stage 0 is read only by stage 1
    assign sr      = s.scl[1] & ~s.scl[2];
    assign sf      = ~s.scl[1] & s.scl[2];
    assign done_ev = s.dq[1] ^ s.dq[2];
    assign p_new   = (meas.prox >= canc) ? meas.prox - canc : 16'h0000;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic       sclh;
        logic [7:0] b;
        logic       above;
        logic       below;
        logic [3:0] an;
        sclh   = s.scl[1] & s.scl[2];
        b      = 8'h00;
        above  = 1'b0;
        below  = 1'b0;
        an     = 4'h0;
        wr_ev  = 1'b0;
        rd_clr = 1'b0;
        next_s = s;
        next_s.scl = {s.scl[1:0], scl_in};
        next_s.sda = {s.sda[1:0], sda_in};
        next_s.dq  = {s.dq[1:0], done_tgl};
        // bus target; never stalls the host, so access goes on under irq
        if (sclh && s.sda[2] && !s.sda[1]) begin
            next_s.ist  = lpt_pkg::I_ADDR;
            next_s.bitc = 4'h0;
            next_s.oe   = 1'b0;
        end else if (sclh && !s.sda[2] && s.sda[1]) begin
            next_s.ist = lpt_pkg::I_IDLE;
            next_s.oe  = 1'b0;
        end else if (sr) begin
            unique case (s.ist)
                lpt_pkg::I_ADDR, lpt_pkg::I_CMD, lpt_pkg::I_WDAT: begin
                    next_s.sh   = {s.sh[6:0], s.sda[1]};
                    next_s.bitc = s.bitc + 4'h1;
                end
                lpt_pkg::I_RDAT: next_s.bitc = s.bitc + 4'h1;
                lpt_pkg::I_MACK: begin
                    if (s.sda[1]) next_s.ist = lpt_pkg::I_IDLE;
                    else next_s.hi = ~s.hi; // word read: low then high
                end
                default: ;
            endcase
        end else if (sf) begin
            unique case (s.ist)
                lpt_pkg::I_ADDR: if (s.bitc == 4'h8) begin
                    if (s.sh[7:1] == lpt_pkg::DEV_ADDR) begin
                        next_s.oe  = 1'b1;
                        next_s.ist = lpt_pkg::I_SACK;
                        next_s.nxt = s.sh[0] ? lpt_pkg::I_RDAT : lpt_pkg::I_CMD;
                    end else begin
                        next_s.ist = lpt_pkg::I_IDLE;
                    end
                end
                lpt_pkg::I_CMD: if (s.bitc == 4'h8) begin
                    next_s.cmd = s.sh;
                    next_s.hi  = 1'b0;
                    next_s.oe  = 1'b1;
                    next_s.ist = lpt_pkg::I_SACK;
                    next_s.nxt = lpt_pkg::I_WDAT;
                end
                lpt_pkg::I_WDAT: if (s.bitc == 4'h8) begin
                    // thresholds and settings land byte by byte
                    if (s.cmd < 8'(lpt_pkg::NUM_WR)) begin
                        next_s.regs[s.cmd[2:0]][{s.hi, 3'h0} +: 8] = s.sh;
                        wr_ev = 1'b1;
                    end
                    next_s.hi  = ~s.hi;
                    next_s.oe  = 1'b1;
                    next_s.ist = lpt_pkg::I_SACK;
                end
                lpt_pkg::I_SACK, lpt_pkg::I_MACK: begin
                    next_s.bitc = 4'h0;
                    next_s.ist  = s.nxt;
                    next_s.oe   = 1'b0;
                    if (s.nxt == lpt_pkg::I_RDAT) begin
                        b            = rd_byte(s);
                        next_s.oe    = ~b[7];
                        next_s.sh    = {b[6:0], 1'b0};
                        next_s.shown = b;
                    end
                end
                lpt_pkg::I_RDAT: begin
                    if (s.bitc == 4'h8) begin
                        next_s.oe  = 1'b0;
                        next_s.ist = lpt_pkg::I_MACK;
                        // only flags the host has seen are cleared
                        if (s.cmd == lpt_pkg::CMD_FLAGS && s.hi) begin
                            next_s.flags = s.flags & ~s.shown;
                            rd_clr       = 1'b1;
                        end
                    end else begin
                        next_s.oe = ~s.sh[7];
                        next_s.sh = {s.sh[6:0], 1'b0};
                    end
                end
                default: ;
            endcase
        end
        // measurement pacing; one-shot mode waits for a trigger
        if (next_s.regs[lpt_pkg::CMD_PRX_CONF3[2:0]][lpt_pkg::ONESHOT_BIT]) begin
            next_s.tmr = 32'h0;
            if (next_s.regs[lpt_pkg::CMD_PRX_CONF3[2:0]][lpt_pkg::TRIG_BIT]) begin
                next_s.req = ~s.req;
                next_s.regs[lpt_pkg::CMD_PRX_CONF3[2:0]][lpt_pkg::TRIG_BIT] = 1'b0;
            end
        end else if (s.tmr >= (BASE_CYC << it_shift(c_a[lpt_pkg::IT_LSB +: 3])) - 1) begin
            next_s.tmr = 32'h0;
            next_s.req = ~s.req;
        end else begin
            next_s.tmr = s.tmr + 32'h1;
        end
        // evaluation once per finished measurement; sets come after clear
        if (done_ev) begin
            next_s.als  = meas.als;
            next_s.prox = p_new;
            above = meas.als > s.regs[lpt_pkg::CMD_ALS_THH[2:0]];
            below = meas.als < s.regs[lpt_pkg::CMD_ALS_THL[2:0]];
            an    = (s.acnt < apers) ? s.acnt + 4'h1 : s.acnt;
            next_s.acnt = (above || below) ? an : 4'h0;
            if ((above || below) && an >= apers && c_a[lpt_pkg::AIEN_BIT]) begin
                next_s.flags[lpt_pkg::FLG_AHI] = next_s.flags[lpt_pkg::FLG_AHI] | above;
                next_s.flags[lpt_pkg::FLG_ALO] = next_s.flags[lpt_pkg::FLG_ALO] | below;
            end
            next_s.ccnt = 3'h0;
            next_s.fcnt = 3'h0;
            // hysteresis: the high threshold sets near, only the low threshold returns to far
            if (!s.near && p_new > s.regs[lpt_pkg::CMD_PRX_THH[2:0]]) begin
                next_s.ccnt = s.ccnt + 3'h1;
                if (s.ccnt + 3'h1 >= ppers) begin
                    next_s.near = 1'b1;
                    next_s.ccnt = 3'h0;
                    if (c_p[lpt_pkg::PIMODE_LSB]) next_s.flags[lpt_pkg::FLG_NEAR] = 1'b1;
                end
            end else if (s.near && p_new < s.regs[lpt_pkg::CMD_PRX_THL[2:0]]) begin
                next_s.fcnt = s.fcnt + 3'h1;
                if (s.fcnt + 3'h1 >= ppers) begin
                    next_s.near = 1'b0;
                    next_s.fcnt = 3'h0;
                    if (c_p[lpt_pkg::PIMODE_LSB + 1]) next_s.flags[lpt_pkg::FLG_FAR] = 1'b1;
                end
            end
        end
        // shared pin: proximity state or any standing flag
        if (next_s.regs[lpt_pkg::CMD_PRX_CONF3[2:0]][lpt_pkg::LOGSEL_BIT]) begin
            next_s.pin = next_s.near;
        end else begin
            next_s.pin = |next_s.flags;
        end
    end

    // synchronous reset to defaults; bus usable straight after
    always_ff @(posedge mclk) begin
        if (rst) begin
            s      <= '0;
            s.regs <= {lpt_pkg::NUM_WR{lpt_pkg::REG_RST}};
            s.scl  <= 3'h7;
            s.sda  <= 3'h7;
        end else begin
            s <= next_s;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = s.oe;
    assign int_out = 1'b0;
    assign int_oe  = s.pin;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_addr_bad;
        sf && s.ist == lpt_pkg::I_ADDR && s.bitc == 4'h8
            && s.sh[7:1] != lpt_pkg::DEV_ADDR;
    endsequence
    sequence s_flag_read;
        rd_clr && !done_ev;
    endsequence

    property p_addr;
        s_addr_bad |=> s.ist == lpt_pkg::I_IDLE && !s.oe;
    endproperty
    a_addr: assert property (p_addr) else $error("answered foreign address");
    property p_clear;
        s_flag_read |=> (s.flags & $past(s.shown)) == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");
    property p_flag_pin;
        !lsel && $rose(|s.flags) |-> int_oe;
    endproperty
    a_flag_pin: assert property (p_flag_pin) else $error("pin not low on flag");
    property p_logic_pin;
        lsel |-> int_oe == s.near;
    endproperty
    a_logic_pin: assert property (p_logic_pin) else $error("logic pin wrong");
    property p_cancel;
        done_ev |=> s.prox == $past(p_new);
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel not applied");
    property p_oneshot;
        osm && $past(osm) && $changed(s.req) |-> $past(wr_ev);
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("untriggered measurement");
    property p_ambient_persistence;
        $rose(s.flags[lpt_pkg::FLG_AHI]) |-> s.acnt >= apers && $past(done_ev);
    endproperty
    a_ambient_persistence: assert property (p_ambient_persistence) else $error("ambient persistence");
    property p_prx_pers;
        $rose(s.near) |-> $past(done_ev) && $past(s.ccnt) + 3'h1 >= ppers;
    endproperty
    a_prx_pers: assert property (p_prx_pers) else $error("proximity persistence");
    property p_hyst;
        done_ev && s.near && p_new >= s.regs[lpt_pkg::CMD_PRX_THL[2:0]] |=> s.near;
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis broken");
endmodule : lpt_top

// file: lpt_fe_model.sv
// front-end stand-in answering each start with one raw result
`timescale 1ns/1ps
module lpt_fe_model (
    input  wire logic          fe_clk,
    input  wire logic          fe_start,
    input  wire logic          slow,
    input  wire logic [15:0]   als_v,
    input  wire logic [15:0]   prox_v,
    output logic               fe_done,
    output lpt_pkg::lpt_meas_t fe_meas,
    output int                 starts,
    output int                 dones
);
    // ----------------
    // conversion
    // ----------------
    // one result per start; junk on the bus outside the done pulse
    initial begin
        fe_done = 1'b0;
        fe_meas = '1;
        starts = 0;
        dones = 0;
        forever begin
            // look after the edge has settled, so the start pulse is seen once
            @(posedge fe_clk);
            #1;
            if (fe_start === 1'b1) begin
                starts = starts + 1;
                repeat (slow ? 6 : 2) @(posedge fe_clk);
                fe_meas <= '{als: als_v, prox: prox_v};
                fe_done <= 1'b1;
                @(posedge fe_clk);
                fe_done <= 1'b0;
                fe_meas <= ~fe_meas; // stale value never lingers
                dones = dones + 1;
            end
        end
    end
endmodule : lpt_fe_model

// file: tb_light_proximity_threshold_irq.sv
// self-checking bench: bus host, front-end stand-in and pin checks
`timescale 1ns/1ps
module tb_light_proximity_threshold_irq;
    localparam int unsigned BASE = 500;
    logic               mclk, rst, fe_clk, scl, host_low, slow, sda_oe, int_oe;
    logic               fe_start, fe_done, a;
    logic [15:0]        als_v, prox_v, w;
    logic [7:0]         r8;
    lpt_pkg::lpt_meas_t fe_meas;
    int                 starts, dones, fail_count, checks_done, n, k;
    // open-drain lines with pull-ups
    wire                sda   = ~(sda_oe | host_low);
    wire                int_n = ~int_oe;
    // ----------------
    // scenario tables
    // ----------------
    logic [7:0]  cmds [7] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h03, 8'h00};
    logic [15:0] vals [7] = '{16'h1000, 16'h0100, 16'h0010, 16'h0020, 16'h0080,
                              16'h0810, 16'h0046};
    logic [15:0] sv [4] = '{16'h2000, 16'h0080, 16'h00a0, 16'h0020};
    logic [15:0] dv [4] = '{16'h2000, 16'h0080, 16'h0090, 16'h0010};
    logic [15:0] fv [4] = '{16'h1000, 16'h2000, 16'h0200, 16'h0100};
    logic [2:0]  itc [5] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b111};
    // clocks, link clock unrelated in phase
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        fe_clk = 1'b0;
        #7.3;
        forever #24 fe_clk = ~fe_clk;
    end
    lpt_top #(.BASE_CYC(BASE)) lpt_top_i (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .int_out(), .int_oe(int_oe), .fe_clk(fe_clk),
        .fe_start(fe_start), .fe_done(fe_done), .fe_meas(fe_meas));
    lpt_fe_model lpt_fe_model_i (
        .fe_clk(fe_clk), .fe_start(fe_start), .slow(slow), .als_v(als_v),
        .prox_v(prox_v), .fe_done(fe_done), .fe_meas(fe_meas), .starts(starts),
        .dones(dones));
    // ----------------
    // tasks
    // ----------------
    task automatic tick(input int c);
        repeat (c) @(negedge mclk);
    endtask : tick
    task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string what, input logic e, input logic g);
        chk_word(what, {15'h0000, e}, {15'h0000, g});
    endtask : chk_bit
    // s=1 start or repeated start, s=0 stop
    task automatic xcond(input logic s);
        tick(2);
        host_low = ~s;
        tick(4);
        scl = 1'b1;
        tick(4);
        host_low = s;
        tick(4);
        if (s) begin
            scl = 1'b0;
        end
    endtask : xcond
    // one bit: six clocks low, six high, sampled mid high phase
    task automatic xbit(input logic b, output logic r);
        tick(2);
        host_low = ~b;
        tick(4);
        scl = 1'b1;
        tick(3);
        r = sda;
        tick(3);
        scl = 1'b0;
    endtask : xbit
    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r,
                         output logic ak);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r[i]);
        end
        xbit(last, ak);
    endtask : xbyte
    task automatic reg_wr(input logic [7:0] cmd, input logic [15:0] d);
        logic [3:0] ak;
        xcond(1'b1);
        xbyte({lpt_pkg::DEV_ADDR, 1'b0}, 1'b1, r8, ak[0]);
        xbyte(cmd, 1'b1, r8, ak[1]);
        xbyte(d[7:0], 1'b1, r8, ak[2]);
        xbyte(d[15:8], 1'b1, r8, ak[3]);
        xcond(1'b0);
        chk_word("write_ack", 16'h0000, {12'h000, ak});
    endtask : reg_wr
    // low byte acked, high byte refused, then stop
    task automatic reg_rd(input logic [7:0] cmd, output logic [15:0] d);
        logic [2:0] ak;
        logic       x;
        xcond(1'b1);
        xbyte({lpt_pkg::DEV_ADDR, 1'b0}, 1'b1, r8, ak[0]);
        xbyte(cmd, 1'b1, r8, ak[1]);
        xcond(1'b1);
        xbyte({lpt_pkg::DEV_ADDR, 1'b1}, 1'b1, r8, ak[2]);
        xbyte(8'hff, 1'b0, d[7:0], x);
        xbyte(8'hff, 1'b1, d[15:8], x);
        xcond(1'b0);
        chk_word("read_ack", 16'h0000, {13'h0000, ak});
    endtask : reg_rd
    task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] e);
        reg_rd(cmd, w);
        chk_word("register", e, w);
    endtask : rd_chk
    // src=1 counts starts, src=0 finished results; bounded
    task automatic wait_ev(input bit src, input int cnt);
        int goal;
        goal = (src ? starts : dones) + cnt;
        n = 0;
        while ((src ? starts : dones) < goal && n < 20000) begin
            tick(1);
            n++;
        end
        if (n >= 20000) begin
            fail_count++;
            $display("mismatch wait expected %0d seen %0d", goal, n);
            give_verdict();
        end
        tick(12); // result crosses into the core
    endtask : wait_ev
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // ----------------
    // main sequence
    // ----------------
    initial begin
        {rst, scl, host_low, slow} = 4'b1100;
        {als_v, prox_v} = {16'h0800, 16'h0000};
        fail_count = 0;
        checks_done = 0;
        tick(40); // link side needs three of its own clocks
        rst = 1'b0;
        tick(10);
        rd_chk(lpt_pkg::CMD_ALS_CONF, lpt_pkg::REG_RST);
        rd_chk(lpt_pkg::CMD_IDENT, lpt_pkg::IDENT_VAL);
        xcond(1'b1);
        xbyte(8'hc2, 1'b1, r8, a);
        xcond(1'b0);
        chk_bit("foreign_addr", 1'b1, a);
        for (int i = 0; i < 7; i++) begin
            reg_wr(cmds[i], vals[i]);
            rd_chk(cmds[i], vals[i]);
        end
        prox_v = 16'h0050; // between thresholds, state stays far
        wait_ev(0, 1);
        reg_wr(lpt_pkg::CMD_PRX_CONF, 16'h0b10);
        // ambient high, ambient low, proximity near, proximity far
        for (int j = 0; j < 4; j++) begin
            wait_ev(0, 1);
            slow = (j >= 2);
            if (j < 2) als_v = sv[j];
            else prox_v = sv[j];
            wait_ev(0, 1);
            chk_bit("int_pin", 1'b1, int_n);
            wait_ev(0, 1);
            chk_bit("int_pin", 1'b0, int_n);
            {als_v, prox_v} = {16'h0800, 16'h0050};
            rd_chk((j < 2) ? lpt_pkg::CMD_ALS_DATA : lpt_pkg::CMD_PRX_DATA, dv[j]);
            rd_chk(lpt_pkg::CMD_FLAGS, fv[j]);
            wait_ev(0, 2);
            chk_bit("int_pin", 1'b1, int_n);
            rd_chk(lpt_pkg::CMD_FLAGS, 16'h0000);
        end
        // logic-output mode ignores the ambient side
        reg_wr(lpt_pkg::CMD_PRX_CONF3, 16'h4000);
        wait_ev(0, 1);
        {als_v, prox_v} = {16'h2000, 16'h00a0};
        wait_ev(0, 2);
        chk_bit("int_pin", 1'b0, int_n);
        prox_v = 16'h0020;
        wait_ev(0, 2);
        chk_bit("int_pin", 1'b1, int_n);
        reg_wr(lpt_pkg::CMD_PRX_CONF3, 16'h0000);
        tick(10);
        chk_bit("int_pin", 1'b0, int_n);
        {als_v, prox_v} = {16'h0800, 16'h0050};
        // one-shot: silent until triggered, then exactly one start
        reg_wr(lpt_pkg::CMD_PRX_CONF3, 16'h0008);
        tick(2100);
        k = starts;
        tick(4100);
        chk_word("starts", 16'h0000, 16'(starts - k));
        reg_wr(lpt_pkg::CMD_PRX_CONF3, 16'h000c);
        tick(4100);
        chk_word("starts", 16'h0001, 16'(starts - k));
        reg_wr(lpt_pkg::CMD_PRX_CONF3, 16'h0000);
        // measurement spacing for five integration codes, one per period
        for (int j = 0; j < 5; j++) begin
            reg_wr(lpt_pkg::CMD_ALS_CONF, {8'h00, itc[j], 5'h00});
            wait_ev(1, 1);
            wait_ev(1, 1);
            chk_word("period", 16'(1 << j), 16'((n + 12 + BASE / 2) / BASE));
        end
        give_verdict();
    end
endmodule : tb_light_proximity_threshold_irq
